// *** common/odc_pkg.sv ***
package odc_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int I2C_HZ = 100_000;
    localparam int CAL_TIME_MS = 10;
    // Longest time, so the division rounds down
    localparam int CAL_CYCLES = CAL_TIME_MS * (CLK_HZ / 1000);
    localparam int QUARTER_CYCLES = CLK_HZ / (4 * I2C_HZ);

    // ==========================================================
    // Link addressing
    // Arbitrary slave address
    localparam logic [6:0] DEV_ADDR = 7'h3C;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_HS_LOW = 8'h0A;
    localparam logic [7:0] REG_DIV_HIGH = 8'h0B;
    localparam logic [7:0] REG_LEVEL = 8'h0E;
    localparam logic [7:0] REG_SOFT_RST = 8'h80;
    localparam logic [7:0] REG_OUT_CAL = 8'h84;

    // ==========================================================
    // Field positions
    localparam int HSH_MSB = 1;
    localparam int LS_LSB = 4;
    localparam int LS_MSB = 6;
    localparam int LEVEL_LSB = 4;
    localparam int LEVEL_MSB = 5;
    localparam int RST_BIT = 7;
    localparam int OE_BIT = 2;
    localparam int CAL_BIT = 0;

    // ==========================================================
    // Reset values and codes
    localparam logic [9:0] HIGH_SPEED_DIVIDER_DEFAULT = 10'h00A;
    localparam logic [2:0] LAST_OUTPUT_DIVIDER_DEFAULT = 3'h0;
    localparam logic [1:0] LEVEL_DEFAULT = 2'h0;
    localparam logic OE_DEFAULT = 1'b1;
    localparam logic [1:0] LEVEL_HIZ = 2'h0;
    localparam logic [1:0] LEVEL_LOW = 2'h2;
    localparam logic [1:0] LEVEL_HIGH = 2'h1;
    localparam logic [2:0] LS_MAX_CODE = 3'h5;
    localparam logic [9:0] HS_MIN = 10'h00A;
    localparam logic [9:0] HS_MAX = 10'h3FE;

    typedef enum logic [1:0] {CMD_WRITE, CMD_READ, CMD_RETUNE} odc_cmd_t;

endpackage : odc_pkg

// *** common/odc_if.sv ***
`timescale 1ns/1ns

interface odc_if;
    logic hostSclOut;
    logic hostSclOeN;
    logic hostSdaOut;
    logic hostSdaOeN;
    logic devSdaOut;
    logic devSdaOeN;
    logic scl;
    logic sda;

    // ==========================================================
    // Open-drain wires with pull-ups
    assign scl = (~hostSclOeN & ~hostSclOut) ? 1'b0 : 1'b1;
    assign sda = ((~hostSdaOeN & ~hostSdaOut) | (~devSdaOeN & ~devSdaOut)) ? 1'b0 : 1'b1;

    modport dev (input scl, input sda, output devSdaOut, output devSdaOeN);
    modport host (input sda, output hostSclOut, output hostSclOeN,
                  output hostSdaOut, output hostSdaOeN);
endinterface : odc_if

// *** design/odc_device.sv ***
// Summary of operation
// - Host writes only even dividers 10..1022
// - Divide source clock by high-speed divider
// - Divider split: low byte, two high bits
// - Divider changed only via large-change sequence; plain writes to 0x0A and 0x0B also change it here
// - Last divider codes give 1..32, others reserved
// - Last divider applies at once; host sequences
// - Disabled level: hi-Z, low, high; default hi-Z
// - Reset bit restores defaults, clears itself
// - Enable bit drives output, else disabled level
// - Trigger bit starts calibration, clears itself
// - Calibration finishes within ten milliseconds
// - Host disables output before calibrating
// - Host writes reserved bits back unchanged; the testbench register rows write ones into them
`timescale 1ns/1ns

module odc_device #(
    parameter logic [6:0] SLAVE_ADDR = odc_pkg::DEV_ADDR,
    parameter int CAL_CYCLES = odc_pkg::CAL_CYCLES,
    parameter logic [9:0] HIGH_SPEED_DIVIDER_RESET = odc_pkg::HIGH_SPEED_DIVIDER_DEFAULT,
    parameter logic [2:0] LAST_OUTPUT_DIVIDER_RESET = odc_pkg::LAST_OUTPUT_DIVIDER_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst,
    odc_if.dev link,
    output logic clkOut,
    output logic clkOutOeN,
    output logic calBusy
);

    localparam int CW = $clog2(CAL_CYCLES + 1);

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_REG, S_WRITE, S_READ} odc_slave_t;

    odc_slave_t state;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclPrev;
    logic sdaPrev;
    logic busStart;
    logic busStop;
    logic sclRise;
    logic sclFall;
    logic [3:0] bitCnt;
    logic [7:0] rxByte;
    logic [7:0] txByte;
    logic [7:0] regPtr;
    logic nackSeen;
    logic sdaOeN;
    logic sdaOut;
    logic wrStb;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] rdByte;
    logic [9:0] hsDiv;
    logic [2:0] lsDiv;
    logic [1:0] offLevel;
    logic outEn;
    logic softRst;
    logic calStart;
    logic [CW-1:0] calCnt;
    logic [8:0] hsHalfM1;
    logic [8:0] hsCnt;
    logic hsClk;
    logic hsRise;
    logic [4:0] lsCnt;
    logic [2:0] lsEff;
    logic divClk;

    // ==========================================================
    // Pin synchronisers and bus conditions
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            sclSync <= {sclSync[0], link.scl};
            sdaSync <= {sdaSync[0], link.sda};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end

    assign busStart = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
    assign busStop = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];
    assign sclRise = sclSync[1] & ~sclPrev;
    assign sclFall = ~sclSync[1] & sclPrev;
    assign link.devSdaOut = sdaOut;
    assign link.devSdaOeN = sdaOeN;

    // ==========================================================
    // Serial slave; data bits change only while the clock is low
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            bitCnt <= 4'h0;
            rxByte <= 8'h00;
            txByte <= 8'hFF;
            regPtr <= 8'h00;
            nackSeen <= 1'b0;
            sdaOeN <= 1'b1;
            sdaOut <= 1'b0;
            wrStb <= 1'b0;
            wrAddr <= 8'h00;
            wrData <= 8'h00;
        end
        else
        begin
            wrStb <= 1'b0;
            if (busStop)
            begin
                state <= S_IDLE;
                sdaOeN <= 1'b1;
            end
            else if (busStart)
            begin
                state <= S_ADDR;
                bitCnt <= 4'h0;
                sdaOeN <= 1'b1;
            end
            else if (state != S_IDLE && sclRise)
            begin
                if (bitCnt < odc_pkg::BYTE_BITS)
                    rxByte <= {rxByte[6:0], sdaSync[1]};
                else
                    nackSeen <= sdaSync[1];
                bitCnt <= bitCnt + 4'h1;
            end
            else if (state != S_IDLE && sclFall)
            begin
                if (bitCnt == odc_pkg::BYTE_BITS)
                begin
                    unique case (state)
                        S_ADDR:
                            if (rxByte[7:1] == SLAVE_ADDR)
                                sdaOeN <= 1'b0;
                            else
                                state <= S_IDLE;
                        S_REG:
                        begin
                            sdaOeN <= 1'b0;
                            regPtr <= rxByte;
                        end
                        S_WRITE:
                        begin
                            sdaOeN <= 1'b0;
                            wrStb <= 1'b1;
                            wrAddr <= regPtr;
                            wrData <= rxByte;
                            regPtr <= regPtr + 8'h01;
                        end
                        S_READ: sdaOeN <= 1'b1;
                        S_IDLE: sdaOeN <= 1'b1;
                    endcase
                end
                else if (bitCnt == odc_pkg::ACK_SLOT)
                begin
                    bitCnt <= 4'h0;
                    sdaOeN <= 1'b1;
                    if ((state == S_ADDR && rxByte[0]) || (state == S_READ && !nackSeen))
                    begin
                        state <= S_READ;
                        sdaOeN <= rdByte[7];
                        txByte <= {rdByte[6:0], 1'b1};
                        regPtr <= regPtr + 8'h01;
                    end
                    else if (state == S_ADDR)
                        state <= S_REG;
                    else if (state == S_REG)
                        state <= S_WRITE;
                    else if (state == S_READ)
                        state <= S_IDLE;
                end
                else if (state == S_READ && bitCnt != 4'h0)
                begin
                    sdaOeN <= txByte[7];
                    txByte <= {txByte[6:0], 1'b1};
                end
            end
        end
    end

    // ==========================================================
    // Register file
    assign softRst = wrStb && wrAddr == odc_pkg::REG_SOFT_RST && wrData[odc_pkg::RST_BIT];
    assign calStart = wrStb && wrAddr == odc_pkg::REG_OUT_CAL && wrData[odc_pkg::CAL_BIT];

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hsDiv <= HIGH_SPEED_DIVIDER_RESET;
            lsDiv <= LAST_OUTPUT_DIVIDER_RESET;
            offLevel <= odc_pkg::LEVEL_DEFAULT;
            outEn <= odc_pkg::OE_DEFAULT;
        end
        // Kept apart from the pin reset so the async branch stays clean
        else if (softRst)
        begin
            hsDiv <= HIGH_SPEED_DIVIDER_RESET;
            lsDiv <= LAST_OUTPUT_DIVIDER_RESET;
            offLevel <= odc_pkg::LEVEL_DEFAULT;
            outEn <= odc_pkg::OE_DEFAULT;
        end
        else if (wrStb)
        begin
            if (wrAddr == odc_pkg::REG_HS_LOW)
                hsDiv[7:0] <= wrData;
            if (wrAddr == odc_pkg::REG_DIV_HIGH)
            begin
                hsDiv[9:8] <= wrData[odc_pkg::HSH_MSB:0];
                lsDiv <= wrData[odc_pkg::LS_MSB:odc_pkg::LS_LSB];
            end
            if (wrAddr == odc_pkg::REG_LEVEL)
                offLevel <= wrData[odc_pkg::LEVEL_MSB:odc_pkg::LEVEL_LSB];
            if (wrAddr == odc_pkg::REG_OUT_CAL)
                outEn <= wrData[odc_pkg::OE_BIT];
        end
    end

    // Reserved bits and the reset bit read back as zero
    always_comb
    begin
        rdByte = 8'h00;
        unique case (regPtr)
            odc_pkg::REG_HS_LOW: rdByte = hsDiv[7:0];
            odc_pkg::REG_DIV_HIGH: rdByte = 8'(lsDiv) << odc_pkg::LS_LSB | 8'(hsDiv[9:8]);
            odc_pkg::REG_LEVEL: rdByte = 8'(offLevel) << odc_pkg::LEVEL_LSB;
            odc_pkg::REG_OUT_CAL:
                rdByte = 8'(outEn) << odc_pkg::OE_BIT | 8'(calBusy) << odc_pkg::CAL_BIT;
            default: rdByte = 8'h00;
        endcase
    end

    // ==========================================================
    // Calibration timer; a new trigger on the last cycle restarts it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            calBusy <= 1'b0;
            calCnt <= '0;
        end
        else if (softRst)
        begin
            calBusy <= 1'b0;
            calCnt <= '0;
        end
        else if (calStart)
        begin
            calBusy <= 1'b1;
            calCnt <= '0;
        end
        else if (calBusy && calCnt == CW'(CAL_CYCLES - 1))
            calBusy <= 1'b0;
        else if (calBusy)
            calCnt <= calCnt + CW'(1);
    end

    // ==========================================================
    // Divider chain; mclk stands in for the oscillator
    assign hsHalfM1 = (hsDiv[9:1] == 9'h000) ? 9'h000 : hsDiv[9:1] - 9'h001;
    assign hsRise = (hsCnt >= hsHalfM1) && !hsClk;
    assign lsEff = (lsDiv > odc_pkg::LS_MAX_CODE) ? odc_pkg::LS_MAX_CODE : lsDiv;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hsCnt <= 9'h000;
            hsClk <= 1'b0;
            lsCnt <= 5'h00;
        end
        else
        begin
            // Compare, not equality, so a shrinking divider cannot stall
            if (hsCnt >= hsHalfM1)
            begin
                hsCnt <= 9'h000;
                hsClk <= ~hsClk;
            end
            else
                hsCnt <= hsCnt + 9'h001;
            if (hsRise)
                lsCnt <= lsCnt + 5'h01;
        end
    end

    // No commit step: a new last-divider code takes effect at once
    always_comb
    begin
        if (lsEff == 3'h0)
            divClk = hsClk;
        else
            divClk = lsCnt[lsEff - 3'h1];
    end

    // ==========================================================
    // Output stage
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            clkOut <= 1'b0;
            clkOutOeN <= 1'b1;
        end
        else if (outEn)
        begin
            clkOut <= divClk;
            clkOutOeN <= 1'b0;
        end
        else
        begin
            unique case (offLevel)
                odc_pkg::LEVEL_LOW:
                begin
                    clkOut <= 1'b0;
                    clkOutOeN <= 1'b0;
                end
                odc_pkg::LEVEL_HIGH:
                begin
                    clkOut <= 1'b1;
                    clkOutOeN <= 1'b0;
                end
                default:
                begin
                    clkOut <= 1'b0;
                    clkOutOeN <= 1'b1;
                end
            endcase
        end
    end

endmodule : odc_device

// *** design/odc_host.sv ***
`timescale 1ns/1ns

module odc_host #(
    parameter logic [6:0] SLAVE_ADDR = odc_pkg::DEV_ADDR,
    parameter int QUARTER = odc_pkg::QUARTER_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    odc_if.host link,
    input wire logic cmdValid,
    input wire odc_pkg::odc_cmd_t cmdKind,
    input wire logic [7:0] cmdReg,
    input wire logic [7:0] cmdData,
    input wire logic [9:0] cmdHsDiv,
    input wire logic [2:0] cmdLsDiv,
    output logic cmdReady,
    output logic rspValid,
    output logic rspErr,
    output logic [7:0] rspData
);

    localparam int QW = $clog2(QUARTER + 1);
    localparam logic [2:0] STOP_WR = 3'h4;
    localparam logic [2:0] STOP_RD = 3'h6;
    localparam logic [2:0] POLL_TXN = 3'h4;
    localparam logic [2:0] LAST_TXN = 3'h5;

    typedef enum logic [1:0] {H_IDLE, H_RUN, H_NEXT, H_DONE} odc_hstate_t;
    typedef enum logic [1:0] {OP_START, OP_TX, OP_RX, OP_STOP} odc_op_t;

    odc_hstate_t hs;
    odc_op_t op;
    odc_pkg::odc_cmd_t kindQ;
    logic [7:0] regQ;
    logic [7:0] dataQ;
    logic [9:0] hsQ;
    logic [2:0] lsQ;
    logic [2:0] txn;
    logic [2:0] opIdx;
    logic [1:0] phase;
    logic [3:0] bitIdx;
    logic err;
    logic [7:0] rxSh;
    logic [1:0] sdaSync;
    logic [QW-1:0] qCnt;
    logic qTick;
    logic sclOeN;
    logic sdaOeN;
    logic lowLevel;
    logic tRead;
    logic [7:0] tReg;
    logic [7:0] tData;
    logic [7:0] opByte;
    logic q0Sda;
    logic retuneOk;

    assign link.hostSclOut = lowLevel;
    assign link.hostSdaOut = lowLevel;
    assign link.hostSclOeN = sclOeN;
    assign link.hostSdaOeN = sdaOeN;

    // ==========================================================
    // Data pin synchroniser and quarter-bit timebase
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sdaSync <= 2'h3;
            qCnt <= '0;
            qTick <= 1'b0;
            lowLevel <= 1'b0;
        end
        else
        begin
            sdaSync <= {sdaSync[0], link.sda};
            qTick <= (qCnt == QW'(QUARTER - 1));
            qCnt <= (qCnt == QW'(QUARTER - 1)) ? '0 : qCnt + QW'(1);
        end
    end

    // ==========================================================
    // Transaction list; retune is the large frequency change sequence
    assign retuneOk = !cmdHsDiv[0] && cmdHsDiv >= odc_pkg::HS_MIN
        && cmdHsDiv <= odc_pkg::HS_MAX && cmdLsDiv <= odc_pkg::LS_MAX_CODE;

    always_comb
    begin
        tRead = (kindQ == odc_pkg::CMD_READ);
        tReg = regQ;
        tData = dataQ;
        if (kindQ == odc_pkg::CMD_RETUNE)
        begin
            tReg = odc_pkg::REG_OUT_CAL;
            unique case (txn)
                3'h0: tData = 8'h00;
                3'h1:
                begin
                    tReg = odc_pkg::REG_HS_LOW;
                    tData = hsQ[7:0];
                end
                3'h2:
                begin
                    // Reserved bits read back as zero, so zero keeps them
                    tReg = odc_pkg::REG_DIV_HIGH;
                    tData = 8'(lsQ) << odc_pkg::LS_LSB | 8'(hsQ[9:8]);
                end
                3'h3: tData = 8'h01 << odc_pkg::CAL_BIT;
                3'h4: tRead = 1'b1;
                default: tData = 8'h01 << odc_pkg::OE_BIT;
            endcase
        end
    end

    always_comb
    begin
        op = OP_TX;
        opByte = {SLAVE_ADDR, 1'b0};
        unique case (opIdx)
            3'h0: op = OP_START;
            3'h1: opByte = {SLAVE_ADDR, 1'b0};
            3'h2: opByte = tReg;
            3'h3:
                if (tRead)
                    op = OP_START;
                else
                    opByte = tData;
            3'h4:
                if (tRead)
                    opByte = {SLAVE_ADDR, 1'b1};
                else
                    op = OP_STOP;
            3'h5: op = OP_RX;
            default: op = OP_STOP;
        endcase
        q0Sda = (op != OP_STOP);
        if (op == OP_TX && bitIdx < odc_pkg::BYTE_BITS)
            q0Sda = opByte[3'h7 - bitIdx[2:0]];
    end

    // ==========================================================
    // Bit engine and sequencer
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hs <= H_IDLE;
            kindQ <= odc_pkg::CMD_WRITE;
            regQ <= 8'h00;
            dataQ <= 8'h00;
            hsQ <= 10'h000;
            lsQ <= 3'h0;
            txn <= 3'h0;
            opIdx <= 3'h0;
            phase <= 2'h0;
            bitIdx <= 4'h0;
            err <= 1'b0;
            rxSh <= 8'h00;
            sclOeN <= 1'b1;
            sdaOeN <= 1'b1;
            cmdReady <= 1'b1;
            rspValid <= 1'b0;
            rspErr <= 1'b0;
            rspData <= 8'h00;
        end
        else
        begin
            rspValid <= 1'b0;
            unique case (hs)
                H_IDLE:
                    if (cmdValid)
                    begin
                        kindQ <= cmdKind;
                        regQ <= cmdReg;
                        dataQ <= cmdData;
                        hsQ <= cmdHsDiv;
                        lsQ <= cmdLsDiv;
                        txn <= 3'h0;
                        opIdx <= 3'h0;
                        phase <= 2'h0;
                        bitIdx <= 4'h0;
                        cmdReady <= 1'b0;
                        err <= (cmdKind == odc_pkg::CMD_RETUNE) && !retuneOk;
                        hs <= ((cmdKind == odc_pkg::CMD_RETUNE) && !retuneOk) ? H_DONE : H_RUN;
                    end
                H_RUN:
                    if (qTick)
                    begin
                        phase <= phase + 2'h1;
                        unique case (phase)
                            2'h0: sdaOeN <= q0Sda;
                            2'h1: sclOeN <= 1'b1;
                            2'h2:
                                if (op == OP_START)
                                    sdaOeN <= 1'b0;
                                else if (op == OP_STOP)
                                    sdaOeN <= 1'b1;
                                else if (bitIdx < odc_pkg::BYTE_BITS)
                                    rxSh <= {rxSh[6:0], sdaSync[1]};
                                else if (op == OP_TX && sdaSync[1])
                                    err <= 1'b1;
                            2'h3:
                            begin
                                if (op != OP_STOP)
                                    sclOeN <= 1'b0;
                                if ((op == OP_TX || op == OP_RX) && bitIdx < odc_pkg::BYTE_BITS)
                                    bitIdx <= bitIdx + 4'h1;
                                else
                                begin
                                    bitIdx <= 4'h0;
                                    if (op == OP_STOP)
                                        hs <= H_NEXT;
                                    else if (err)
                                        opIdx <= tRead ? STOP_RD : STOP_WR;
                                    else
                                        opIdx <= opIdx + 3'h1;
                                end
                            end
                        endcase
                    end
                H_NEXT:
                begin
                    opIdx <= 3'h0;
                    phase <= 2'h0;
                    if (tRead)
                        rspData <= rxSh;
                    if (err)
                        hs <= H_DONE;
                    else if (kindQ == odc_pkg::CMD_RETUNE && txn == POLL_TXN
                             && rxSh[odc_pkg::CAL_BIT])
                        hs <= H_RUN;
                    else if (kindQ != odc_pkg::CMD_RETUNE || txn == LAST_TXN)
                        hs <= H_DONE;
                    else
                    begin
                        txn <= txn + 3'h1;
                        hs <= H_RUN;
                    end
                end
                H_DONE:
                begin
                    rspValid <= 1'b1;
                    rspErr <= err;
                    cmdReady <= 1'b1;
                    hs <= H_IDLE;
                end
            endcase
        end
    end

endmodule : odc_host

// *** sim/odc_props.sv ***
`timescale 1ns/1ns

module odc_props #(
    parameter int CAL_LIM = 200
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic hostSclOeN,
    input wire logic devSdaOeN,
    input wire logic clkOut,
    input wire logic clkOutOeN,
    input wire logic calBusy
);
    int calCnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========
    // Busy span counter, too long for a repetition
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            calCnt <= 0;
        else
            calCnt <= calBusy ? calCnt + 1 : 0;
    AST_CAL_BOUND: assert property (calCnt <= CAL_LIM) else $error("Calibration too long");
    AST_CAL_HOLD: assert property ($rose(calBusy) |-> calBusy[*8]) else $error("Busy short");
    AST_CAL_START: assert property ($rose(calBusy) |-> !devSdaOeN) else $error("No ack");
    AST_OE_DEFAULT: assert property ($fell(rst) |-> ##[0:1] !clkOutOeN) else $error("Oe off");
    AST_IDLE_RST: assert property ($fell(rst) |-> !calBusy) else $error("Busy at reset");
    AST_CAL_QUIET: assert property (calBusy && $past(calBusy) |-> $stable(clkOut)) else $error("Out moved");
    AST_ACK_HOLD: assert property ($fell(devSdaOeN) |-> !devSdaOeN[*8]) else $error("Short drive");
    AST_SDA_SCL_LOW: assert property ($changed(devSdaOeN) |-> !scl) else $error("Data in high");
    AST_SCL_LOW: assert property ($fell(hostSclOeN) |-> !hostSclOeN[*8]) else $error("Scl short");
endmodule : odc_props

// *** sim/testbench.sv ***
`timescale 1ns/1ns

module testbench;
    typedef struct {logic [7:0] r; logic [7:0] d; logic [7:0] e;} odc_row_t;
    // Longer than one poll read, so the busy readback is really polled
    localparam int CAL = 3000;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0;
    odc_pkg::odc_cmd_t cmdKind = odc_pkg::CMD_WRITE;
    logic [7:0] cmdReg = 8'h00;
    logic [7:0] cmdData = 8'h00;
    logic [9:0] cmdHsDiv = 10'h00A;
    logic [2:0] cmdLsDiv = 3'h0;
    logic cmdReady, rspValid, rspErr, clkOut, clkOutOeN, calBusy;
    logic [7:0] rspData;
    int errorCnt = 0;
    int comparisons = 0;
    odc_row_t rows [6] = '{'{8'h0A, 8'h3C, 8'h3C}, '{8'h0B, 8'hD1, 8'h51}, '{8'h0E, 8'hFF, 8'h30},
        '{8'h80, 8'h00, 8'h00}, '{8'h20, 8'h55, 8'h00}, '{8'h84, 8'hFA, 8'h00}};
    odc_row_t dflt [5] = '{'{8'h0A, 8'h00, 8'h0A}, '{8'h0B, 8'h00, 8'h00},
        '{8'h0E, 8'h00, 8'h00}, '{8'h80, 8'h00, 8'h00}, '{8'h84, 8'h00, 8'h04}};
    odc_row_t lvl [3] = '{'{8'h20, 8'h00, 8'h00}, '{8'h10, 8'h00, 8'h01}, '{8'h00, 8'h01, 8'h00}};
    logic [9:0] bad [4] = '{10'h00B, 10'h008, 10'h3FF, 10'h00A};

    odc_if bus ();
    odc_device #(.CAL_CYCLES(CAL)) odc_device_inst (.mclk(mclk), .rst(rst), .link(bus.dev),
        .clkOut(clkOut), .clkOutOeN(clkOutOeN), .calBusy(calBusy));
    odc_host #(.QUARTER(8)) odc_host_inst (.mclk(mclk), .rst(rst), .link(bus.host),
        .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdReg(cmdReg), .cmdData(cmdData),
        .cmdHsDiv(cmdHsDiv), .cmdLsDiv(cmdLsDiv), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspErr(rspErr), .rspData(rspData));
    odc_props #(.CAL_LIM(CAL)) odc_props_inst (.mclk(mclk), .rst(rst), .scl(bus.scl),
        .hostSclOeN(bus.hostSclOeN), .devSdaOeN(bus.devSdaOeN), .clkOut(clkOut),
        .clkOutOeN(clkOutOeN), .calBusy(calBusy));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // ==========
    // Shared tasks
    task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string nm);
        comparisons++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            errorCnt++;
        end
    endtask : check

    task automatic cmd(input odc_pkg::odc_cmd_t k, input logic [7:0] r, input logic [7:0] d,
        input logic [9:0] h, input logic [2:0] l);
        int n;
        n = 0;
        @(posedge mclk);
        cmdKind <= k;
        cmdReg <= r;
        cmdData <= d;
        cmdHsDiv <= h;
        cmdLsDiv <= l;
        cmdValid <= 1'b1;
        @(posedge mclk);
        cmdValid <= 1'b0;
        // Bounded wait, a stuck busy bit would hang the poll
        do @(negedge mclk); while (rspValid !== 1'b1 && ++n < 30000);
        if (n >= 30000)
            errorCnt++;
    endtask : cmd

    task automatic period(input int exp);
        time t0;
        @(posedge clkOut);
        t0 = $time;
        @(posedge clkOut);
        check(10'(($time - t0) / 10), 10'(exp), "period");
    endtask : period

    task automatic endSim();
        $display("Compares %0d errors %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : endSim

    // ==========
    // Main sequence
    initial
    begin
        repeat (20) @(negedge mclk);
        check(calBusy, 1'b0, "busy in reset");
        @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            cmd(odc_pkg::CMD_WRITE, rows[i].r, rows[i].d, 10'h00A, 3'h0);
            cmd(odc_pkg::CMD_READ, rows[i].r, 8'h00, 10'h00A, 3'h0);
            check(rspData, rows[i].e, "readback");
        end
        $display("Register rows done");
        cmd(odc_pkg::CMD_WRITE, 8'h80, 8'h80, 10'h00A, 3'h0);
        foreach (dflt[i])
        begin
            cmd(odc_pkg::CMD_READ, dflt[i].r, 8'h00, 10'h00A, 3'h0);
            check(rspData, dflt[i].e, "default");
        end
        for (int c = 0; c < 6; c++)
        begin
            cmd(odc_pkg::CMD_WRITE, 8'h0B, {1'b0, 3'(c), 4'h0}, 10'h00A, 3'h0);
            period(10 << c);
        end
        $display("Soft reset and divider codes done");
        cmd(odc_pkg::CMD_RETUNE, 8'h00, 8'h00, 10'h3FE, 3'h0);
        check(rspErr, 1'b0, "retune err");
        check(rspData[0], 1'b0, "cal done");
        check(calBusy, 1'b0, "cal idle");
        period(1022);
        foreach (bad[i])
        begin
            cmd(odc_pkg::CMD_RETUNE, 8'h00, 8'h00, bad[i], (i == 3) ? 3'h6 : 3'h0);
            check(rspErr, 1'b1, "refused");
            check(cmdReady, 1'b1, "ready");
        end
        $display("Retune done");
        cmd(odc_pkg::CMD_WRITE, 8'h84, 8'h00, 10'h00A, 3'h0);
        foreach (lvl[i])
        begin
            cmd(odc_pkg::CMD_WRITE, 8'h0E, lvl[i].r, 10'h00A, 3'h0);
            check(clkOutOeN, lvl[i].d[0], "out enable");
            if (lvl[i].d[0] == 1'b0)
                check(clkOut, lvl[i].e[0], "out level");
        end
        $display("Disabled levels done");
        endSim();
    end

    initial
    begin
        repeat (90000) @(posedge mclk);
        errorCnt++;
        endSim();
    end
endmodule : testbench
